// ==== hw/dcf_flag_ctrl.sv ====
// dual-clock fifo occupancy, read-size handling and status flags
//
// Functional notes
// - empty releases on second read clock after write
// - word/byte reads: empty on final piece only
// - full releases on second write clock after read
// - last piece of long word frees location
// - almost-empty releases two read clocks later
// - almost-full releases two write clocks later
// - write needs select low, direction high, no mailbox
// - read needs select low, direction low, size valid
// - almost-empty level drops on last piece
`timescale 1ns/1ns
module dcf_flag_ctrl
    import dcf_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic write_port_clock,
    input wire logic write_port_select_n,
    input wire logic write_port_direction,
    input wire logic write_port_mailbox_sel,
    input wire logic read_port_clock,
    input wire logic read_port_select_n,
    input wire logic read_port_direction,
    input wire logic read_size_sel_lo,
    input wire logic read_size_sel_hi,
    input wire logic [5:0] almost_empty_offset,
    input wire logic [5:0] almost_full_offset,
    output logic empty_flag_n,
    output logic almost_empty_n,
    output logic full_flag_n,
    output logic almost_full_n,
    output logic [6:0] fill_level
);

    dcf_state_t q_ff;
    dcf_state_t nxt_q;

    // -------------------------------------------------------------
    // port clock edges and cycle qualifiers
    // -------------------------------------------------------------
    // port clocks are sampled, so a port clock must stay well below
    // half of sys_clk; edges are seen on the second synchroniser stage
    logic wr_edge;
    logic rd_edge;
    logic wr_ok;
    logic rd_ok;
    logic rd_last;
    logic rd_done;
    logic [6:0] nxt_count;
    logic [6:0] ae_level;
    logic [6:0] af_level;
    dcf_flags_t raw;

    assign wr_edge = q_ff.wr_s2.clk & ~q_ff.wclk_prev;
    assign rd_edge = q_ff.rd_s2.clk & ~q_ff.rclk_prev;
    // a full fifo ignores writes, an empty one ignores reads
    assign wr_ok = wr_edge & ~q_ff.wr_s2.select_n & q_ff.wr_s2.direction
                 & ~q_ff.wr_s2.mailbox_sel & q_ff.flags.full_n;
    assign rd_ok = rd_edge & ~q_ff.rd_s2.select_n & ~q_ff.rd_s2.direction
                 & (q_ff.rd_s2.size != DCF_SIZE_MAIL)
                 & q_ff.flags.empty_n;
    assign rd_last = (q_ff.rd_s2.size == DCF_SIZE_LONG)
                   | ((q_ff.rd_s2.size == DCF_SIZE_WORD)
                      & (q_ff.part == DCF_PART_WORD_LAST))
                   | (q_ff.part == DCF_PART_BYTE_LAST);
    assign rd_done = rd_ok & rd_last;
    assign nxt_count = q_ff.count + (wr_ok ? DCF_ONE : 7'h00)
                     - (rd_done ? DCF_ONE : 7'h00);
    assign ae_level = {1'b0, almost_empty_offset};
    assign af_level = DCF_DEPTH - {1'b0, almost_full_offset};

    // -------------------------------------------------------------
    // state update
    // -------------------------------------------------------------
    always_comb begin
        nxt_q = q_ff;
        nxt_q.wr_s1 = '{write_port_clock, write_port_select_n,
                        write_port_direction, write_port_mailbox_sel};
        nxt_q.wr_s2 = q_ff.wr_s1;
        nxt_q.rd_s1 = '{read_port_clock, read_port_select_n,
                        read_port_direction,
                        {read_size_sel_hi, read_size_sel_lo}};
        nxt_q.rd_s2 = q_ff.rd_s1;
        nxt_q.wclk_prev = q_ff.wr_s2.clk;
        nxt_q.rclk_prev = q_ff.rd_s2.clk;
        nxt_q.count = nxt_count;
        if (rd_ok) begin
            nxt_q.part = rd_last ? 2'h0 : q_ff.part + 2'h1;
        end
        // raw flags, active low
        raw.empty_n = (nxt_count != 7'h00);
        raw.almost_empty_n = (nxt_count > ae_level);
        raw.full_n = (nxt_count != DCF_DEPTH);
        raw.almost_full_n = (nxt_count < af_level);
        // asserting edges act at once in their own domain; releases
        // caused by the far port pass two port-clock stages
        if (rd_edge) begin
            nxt_q.stage1.empty_n = raw.empty_n;
            nxt_q.flags.empty_n = q_ff.stage1.empty_n & raw.empty_n;
            nxt_q.stage1.almost_empty_n = raw.almost_empty_n;
            nxt_q.flags.almost_empty_n = q_ff.stage1.almost_empty_n
                                       & raw.almost_empty_n;
        end
        if (rd_done) begin
            nxt_q.flags.empty_n = nxt_q.flags.empty_n & raw.empty_n;
        end
        if (wr_edge) begin
            nxt_q.stage1.full_n = raw.full_n;
            nxt_q.flags.full_n = q_ff.stage1.full_n & raw.full_n;
            nxt_q.stage1.almost_full_n = raw.almost_full_n;
            nxt_q.flags.almost_full_n = q_ff.stage1.almost_full_n
                                      & raw.almost_full_n;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            q_ff <= '0;
            q_ff.stage1.empty_n <= DCF_EMPTY_N_RST;
            q_ff.flags.empty_n <= DCF_EMPTY_N_RST;
            q_ff.stage1.almost_empty_n <= DCF_EMPTY_N_RST;
            q_ff.flags.almost_empty_n <= DCF_EMPTY_N_RST;
            q_ff.stage1.full_n <= DCF_FULL_N_RST;
            q_ff.flags.full_n <= DCF_FULL_N_RST;
            q_ff.stage1.almost_full_n <= DCF_FULL_N_RST;
            q_ff.flags.almost_full_n <= DCF_FULL_N_RST;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign empty_flag_n = q_ff.flags.empty_n;
    assign almost_empty_n = q_ff.flags.almost_empty_n;
    assign full_flag_n = q_ff.flags.full_n;
    assign almost_full_n = q_ff.flags.almost_full_n;
    assign fill_level = q_ff.count;

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    sequence s_write_only;
        wr_ok && !rd_done;
    endsequence

    sequence s_last_read_empties;
        rd_done && !wr_ok && q_ff.count == DCF_ONE;
    endsequence

    property p_write_counts;
        @(posedge sys_clk) disable iff (rst)
        s_write_only |=> q_ff.count == $past(q_ff.count) + DCF_ONE;
    endproperty
    a_write_counts: assert property (p_write_counts)
        else $error("write did not raise fill level");

    property p_partial_read_keeps;
        @(posedge sys_clk) disable iff (rst)
        rd_ok && !rd_last && !wr_ok |=> q_ff.count == $past(q_ff.count);
    endproperty
    a_partial_read_keeps: assert property (p_partial_read_keeps)
        else $error("partial read changed fill level");

    property p_mail_not_fifo;
        @(posedge sys_clk) disable iff (rst)
        rd_edge && q_ff.rd_s2.size == DCF_SIZE_MAIL && !wr_ok
            |=> q_ff.count == $past(q_ff.count);
    endproperty
    a_mail_not_fifo: assert property (p_mail_not_fifo)
        else $error("mailbox size select consumed fifo data");

    property p_empty_on_last;
        @(posedge sys_clk) disable iff (rst)
        s_last_read_empties |=> !empty_flag_n;
    endproperty
    a_empty_on_last: assert property (p_empty_on_last)
        else $error("empty not asserted by final piece");

    property p_empty_release;
        @(posedge sys_clk) disable iff (rst)
        $rose(empty_flag_n) |-> $past(rd_edge) && q_ff.count != 7'h00
            && $past(q_ff.stage1.empty_n);
    endproperty
    a_empty_release: assert property (p_empty_release)
        else $error("empty released off a read clock edge");

    property p_full_on_write;
        @(posedge sys_clk) disable iff (rst)
        s_write_only ##0 q_ff.count == DCF_DEPTH - DCF_ONE |=> !full_flag_n;
    endproperty
    a_full_on_write: assert property (p_full_on_write)
        else $error("full not asserted on filling write");

    property p_full_release;
        @(posedge sys_clk) disable iff (rst)
        $rose(full_flag_n) |-> $past(wr_edge) && q_ff.count != DCF_DEPTH
            && $past(q_ff.stage1.full_n);
    endproperty
    a_full_release: assert property (p_full_release)
        else $error("full released without two write stages");

    property p_ae_release;
        @(posedge sys_clk) disable iff (rst)
        $rose(almost_empty_n) |-> $past(rd_edge) && q_ff.count > ae_level;
    endproperty
    a_ae_release: assert property (p_ae_release)
        else $error("almost-empty released at wrong level");

    property p_af_release;
        @(posedge sys_clk) disable iff (rst)
        $rose(almost_full_n) |-> $past(wr_edge) && q_ff.count < af_level;
    endproperty
    a_af_release: assert property (p_af_release)
        else $error("almost-full released at wrong level");

    property p_ae_drop;
        @(posedge sys_clk) disable iff (rst)
        rd_done && !wr_ok && q_ff.count == ae_level + DCF_ONE
            |=> !almost_empty_n;
    endproperty
    a_ae_drop: assert property (p_ae_drop)
        else $error("almost-empty missed last-piece decrement");

endmodule

// ==== inc/dcf_pkg.sv ====
// constants and carrier types for the dual-clock fifo flag logic
package dcf_pkg;
    localparam int unsigned DCF_DEPTH_W = 7;
    localparam logic [6:0] DCF_DEPTH = 7'h40;
    localparam logic [6:0] DCF_ONE = 7'h01;
    localparam logic [1:0] DCF_PART_WORD_LAST = 2'h1;
    localparam logic [1:0] DCF_PART_BYTE_LAST = 2'h3;
    // size select codes {hi, lo}; 2'h3 addresses the mailbox, not the fifo
    localparam logic [1:0] DCF_SIZE_LONG = 2'h0;
    localparam logic [1:0] DCF_SIZE_WORD = 2'h1;
    localparam logic [1:0] DCF_SIZE_BYTE = 2'h2;
    localparam logic [1:0] DCF_SIZE_MAIL = 2'h3;
    // flag levels after reset (active low flags)
    localparam logic DCF_EMPTY_N_RST = 1'b0;
    localparam logic DCF_FULL_N_RST = 1'b1;

    typedef struct packed {
        logic clk;
        logic select_n;
        logic direction;
        logic mailbox_sel;
    } dcf_wr_pins_t;

    typedef struct packed {
        logic clk;
        logic select_n;
        logic direction;
        logic [1:0] size;
    } dcf_rd_pins_t;

    typedef struct packed {
        logic empty_n;
        logic almost_empty_n;
        logic full_n;
        logic almost_full_n;
    } dcf_flags_t;

    typedef struct packed {
        dcf_wr_pins_t wr_s1;
        dcf_wr_pins_t wr_s2;
        dcf_rd_pins_t rd_s1;
        dcf_rd_pins_t rd_s2;
        logic wclk_prev;
        logic rclk_prev;
        logic [6:0] count;
        logic [1:0] part;
        dcf_flags_t stage1;
        dcf_flags_t flags;
    } dcf_state_t;
endpackage

// ==== verif/dcf_port_host.sv ====
// host-side port clock model for one fifo port
`timescale 1ns/1ns
module dcf_port_host
    import dcf_pkg::*;
(
    input wire logic sys_clk,
    input wire logic go,
    output logic pclk,
    output logic idle
);
    // ----
    // one port cycle: clock high 3 then low 3 system cycles
    // ----
    // the clock stands low between cycles, as a gated host clock would
    logic [2:0] cnt_ff = 3'h0;
    always @(posedge sys_clk) begin
        if (cnt_ff != 3'h0) begin
            cnt_ff <= cnt_ff - 3'h1;
        end else if (go) begin
            cnt_ff <= 3'h6;
        end
    end
    assign pclk = cnt_ff > 3'h3;
    assign idle = cnt_ff == 3'h0;
endmodule

// ==== verif/dcf_flag_ctrl_tb.sv ====
// self-checking bench for the dual-clock fifo flag logic
`timescale 1ns/1ns
module dcf_flag_ctrl_tb;
    import dcf_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic wgo = 1'b0;
    logic rgo = 1'b0;
    logic wsel_n = 1'b1;
    logic wdir = 1'b0;
    logic wmb = 1'b0;
    logic rsel_n = 1'b1;
    logic rdir = 1'b1;
    logic [1:0] rsize = 2'h0;
    logic [5:0] ae_off = 6'h01;
    logic [5:0] af_off = 6'h01;
    logic wclk, rclk, widle, ridle, ef_n, ae_n, ff_n, af_n;
    logic [6:0] fill;
    logic [6:0] seen = 7'h00;
    logic [6:0] notes[$];
    int bad_count = 0;
    int tests_run = 0;
    int lvl = 0;
    int pc = 0;

    initial forever #10 sys_clk = ~sys_clk;

    dcf_port_host whost (.sys_clk(sys_clk), .go(wgo), .pclk(wclk),
        .idle(widle));
    dcf_port_host rhost (.sys_clk(sys_clk), .go(rgo), .pclk(rclk),
        .idle(ridle));
    dcf_flag_ctrl dut (.sys_clk(sys_clk), .rst(rst),
        .write_port_clock(wclk), .write_port_select_n(wsel_n),
        .write_port_direction(wdir), .write_port_mailbox_sel(wmb),
        .read_port_clock(rclk), .read_port_select_n(rsel_n),
        .read_port_direction(rdir), .read_size_sel_lo(rsize[0]),
        .read_size_sel_hi(rsize[1]), .almost_empty_offset(ae_off),
        .almost_full_offset(af_off), .empty_flag_n(ef_n),
        .almost_empty_n(ae_n), .full_flag_n(ff_n),
        .almost_full_n(af_n), .fill_level(fill));

    // ----
    // checking and port cycles
    // ----
    task automatic check(input logic [6:0] got, input logic [6:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic conclude();
        $display("checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // qualifiers settle three cycles before the port clock rises
    task automatic cyc(input bit r);
        repeat (3) @(negedge sys_clk);
        rgo = r;
        wgo = !r;
        @(negedge sys_clk);
        rgo = 1'b0;
        wgo = 1'b0;
        for (int i = 0; i < 20 && !(widle && ridle); i++) @(negedge sys_clk);
        repeat (2) @(negedge sys_clk);
    endtask

    // q = {select_n, direction, mailbox}
    task automatic wr(input logic [2:0] q);
        {wsel_n, wdir, wmb} = q;
        if (q == 3'b010 && lvl < 64) begin
            lvl++;
            notes.push_back(7'(lvl));
        end
        cyc(1'b0);
    endtask

    // q = {select_n, direction, size}
    task automatic rd(input logic [3:0] q);
        int need;
        {rsel_n, rdir, rsize} = q;
        need = q[1:0] == DCF_SIZE_LONG ? 1 : q[1:0] == DCF_SIZE_WORD ? 2 : 4;
        if (q[3:2] == 2'b00 && q[1:0] != DCF_SIZE_MAIL && lvl > 0) begin
            pc++;
            // pieces are counted across size changes: a word read closes
            // the long word on the second or fourth piece, a byte on the
            // fourth, a long-word read always
            if (need == 1 || pc == 4 || (need == 2 && pc == 2)) begin
                pc = 0;
                lvl--;
                notes.push_back(7'(lvl));
            end
        end
        cyc(1'b1);
    endtask

    task automatic idle(input bit r);
        repeat (3) if (r) rd(4'hc); else wr(3'b100);
    endtask

    always @(negedge sys_clk) begin
        if (!rst && fill !== seen) begin
            seen = fill;
            check(fill, notes.size() > 0 ? notes.pop_front() : 7'hxx);
        end
    end

    initial begin
        // a clean run takes a few thousand cycles; this is 20000
        #400000;
        bad_count++;
        conclude();
    end

    // ----
    // main sequence
    // ----
    initial begin
        void'($urandom(98));
        ae_off = 6'($urandom_range(40, 1));
        af_off = 6'($urandom_range(40, 1));
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        rst = 1'b0;
        repeat (3) @(negedge sys_clk);
        check(7'({ef_n, ae_n, ff_n, af_n}), 7'h03);
        wr(3'b110);
        wr(3'b000);
        wr(3'b011);
        wr(3'b010);
        check(7'(ef_n), 7'h00);
        idle(1'b1);
        check(7'(ef_n), 7'h01);
        rd(4'h3);
        rd(4'h8);
        rd(4'h4);
        rd(4'h1);
        check(7'(ef_n), 7'h01);
        rd(4'h1);
        check(7'(ef_n), 7'h00);
        for (int i = 0; i < 64; i++) begin
            wr(3'b010);
            if (lvl == ae_off || lvl == ae_off + 1) begin
                idle(1'b1);
                check(7'(ae_n), 7'(lvl > ae_off));
            end
        end
        check(7'({ff_n, af_n}), 7'h00);
        wr(3'b010);
        repeat (3) rd(4'h2);
        check(7'(ff_n), 7'h00);
        rd(4'h2);
        check(7'(ff_n), 7'h00);
        idle(1'b0);
        check(7'(ff_n), 7'h01);
        while (lvl > 0) begin
            rd({2'b00, 2'($urandom_range(2))});
            if (lvl == 64 - af_off || lvl == 63 - af_off) begin
                idle(1'b0);
                check(7'(af_n), 7'(lvl < 64 - af_off));
            end
        end
        check(7'({ef_n, ae_n}), 7'h00);
        check(7'(notes.size()), 7'h00);
        conclude();
    end
endmodule
